/* bcg_blank_timer.sv */
/*
  current-limit one-shot: trips when sensed current passes a fifth of
  the limit level and blanks the low side for a set number of cycles.
  assumes both levels are already synchronous to clk.
*/
`timescale 1ns/1ns
module bcg_blank_timer #(
  parameter int LEVEL_W = 12,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // levels and off-time
  input wire logic [LEVEL_W-1:0] currentSenseIn,
  input wire logic [LEVEL_W-1:0] currentLimitLevel,
  input wire logic [CNT_W-1:0] offTimeSetting,
  // blanking window
  output logic blankActive
);

  logic [CNT_W-1:0] count_reg;
  logic [LEVEL_W+2:0] senseScaled;
  logic [LEVEL_W+2:0] limitScaled;
  logic trip;

  // compare sense*5 with limit, avoids a divider
  assign senseScaled = {3'h0, currentSenseIn} * (LEVEL_W+3)'(bcg_pkg::TRIP_DIV);
  assign limitScaled = {3'h0, currentLimitLevel};
  assign trip = senseScaled > limitScaled; // [R05]

  // one-shot counter; retrigger ignored while blanking runs
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - CNT_W'(1);
    end else if (trip && offTimeSetting != '0) begin
      count_reg <= offTimeSetting; // [R20]
    end
  end

  assign blankActive = (count_reg != '0);

endmodule

/* bcg_bridge_model.sv */
/*
  behavioural power bridge: a sensed current appears only while a
  low and a high switch conduct and the bench asks for overload.
  assumes one clock and registered gate drives.
*/
`timescale 1ns/1ns
module bcg_bridge_model #(
  parameter logic [11:0] TRIP_LEVEL = 12'h040
) (
  // clock
  input wire logic clk,
  // gate drives, bit 0 is phase a
  input wire logic [2:0] lowDrive,
  input wire logic [2:0] highDrive_n,
  // overcurrent request from the bench
  input wire logic overload,
  // sensed current level
  output logic [11:0] currentSenseIn = 12'h000
);
  // current falls as soon as the low side is blanked, so no retrigger
  always_ff @(posedge clk) begin
    if (overload && lowDrive != 3'h0 && highDrive_n != 3'h7) begin
      currentSenseIn <= TRIP_LEVEL;
    end else begin
      currentSenseIn <= 12'h000;
    end
  end
endmodule

/* bcg_commutation_gating.sv */
/*
  commutation state machine and gate output logic for a sensorless
  three-phase motor controller: align, ramp and run modes, direction,
  back-emf sense select, pwm and current-limit gating, undervoltage.
  assumes analog blocks deliver ticks and levels on pins; pin inputs
  are synchronised here, the levels are taken as quasi-static.
*/
// Notes on behaviour
// [R01] low-side gate outputs are active high.
// [R02] high-side gate outputs are active low.
// [R03] outputs combine commutation state, pwm duty gating and current blanking.
// [R04] current limit forces only low sides off for a fixed time.
// [R05] one-shot trips when sense exceeds 0.2 times the limit level.
// [R06] integrator sets off-time no longer than pwm period, 20 to 40 us.
// [R07] off-time should respect bridge minimum on time, about 5 us.
// [R08] each running state has one low and one high switch, different phases.
// [R09] each oscillator tick advances the state by one.
// [R10] forward order A to F with given switches and sensed phase.
// [R11] align turns on B low plus A and C high, no sensing.
// [R12] direction input low steps the states in reverse order.
// [R13] controller changes direction only with motor at rest; the code takes the direction pin at every tick in ramp and run.
// [R14] power cycle or brake with align input at zero restarts start-up.
// [R15] undervoltage forces all six gate outputs off.
// [R16] start-up order: align, open-loop ramp, then pll run.
// [R17] power-up enters align and holds it until the align timer ends.
// [R18] ramp steps A to F for fixed time, back-emf sampling off.
// [R19] run mode enables back-emf sensing under pll timing.
// [R20] oscillator tick is a synchronised pulse; off-time counted in cycles.
// [R21] pwm off time masks the active low side, high side untouched.
`timescale 1ns/1ns
module bcg_commutation_gating #(
  parameter int LEVEL_W = 12,
  parameter int CNT_W = bcg_pkg::OFF_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins from the analog side
  input wire logic commutationTickIn,
  input wire logic directionForward,
  input wire logic brake,
  input wire logic alignTimingInput,
  input wire logic rampTimingInput,
  input wire logic pwmOn,
  input wire logic undervoltageFlag_n,
  // current limit levels and off-time
  input wire logic [LEVEL_W-1:0] currentSenseIn,
  input wire logic [LEVEL_W-1:0] currentLimitLevel,
  input wire logic [CNT_W-1:0] offTimeSetting,
  // gate drives
  output logic phaseALowDrive,
  output logic phaseBLowDrive,
  output logic phaseCLowDrive,
  output logic phaseAHighDrive_n,
  output logic phaseBHighDrive_n,
  output logic phaseCHighDrive_n,
  // sense select and status
  output logic phaseASense,
  output logic phaseBSense,
  output logic phaseCSense,
  output logic backEmfEnable,
  output logic [1:0] startMode
);

  // two-flop synchronisers for all pin inputs, in one vector
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA_reg;
  logic [NSYNC-1:0] syncB_reg;
  logic tickDly_reg;
  logic tickPulse;
  logic fwd;
  logic brk;
  logic alignDone;
  logic rampDone;
  logic pwmGate;
  logic uvOk;

  assign pinRaw = {commutationTickIn, directionForward, brake, alignTimingInput,
                   rampTimingInput, pwmOn, undervoltageFlag_n};

  always_ff @(posedge clk) begin
    if (srst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= pinRaw;
      syncB_reg <= syncA_reg;
    end
  end

  assign fwd = syncB_reg[5];
  assign brk = syncB_reg[4];
  assign alignDone = syncB_reg[3];
  assign rampDone = syncB_reg[2];
  assign pwmGate = syncB_reg[1];
  assign uvOk = syncB_reg[0];

  // rising edge of the synchronised tick gives one advance pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      tickDly_reg <= 1'b0;
    end else begin
      tickDly_reg <= syncB_reg[6];
    end
  end

  assign tickPulse = syncB_reg[6] & ~tickDly_reg; // [R20]

  // restart request: brake held with the align timer discharged
  logic restart;
  assign restart = brk & ~alignDone; // [R14]

  // start-up mode sequencer
  bcg_pkg::bcg_mode_t mode_reg;
  bcg_pkg::bcg_mode_t mode_next;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      bcg_pkg::MODE_ALIGN: begin
        if (alignDone) begin
          mode_next = bcg_pkg::MODE_RAMP; // [R16] [R17]
        end
      end
      bcg_pkg::MODE_RAMP: begin
        if (rampDone) begin
          mode_next = bcg_pkg::MODE_RUN; // [R18]
        end
      end
      bcg_pkg::MODE_RUN: begin
        mode_next = bcg_pkg::MODE_RUN; // [R19]
      end
      default: begin
        mode_next = bcg_pkg::MODE_ALIGN;
      end
    endcase
    if (restart) begin
      mode_next = bcg_pkg::MODE_ALIGN; // [R14]
    end
  end

  // reset acts as the power cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= bcg_pkg::MODE_ALIGN; // [R14] [R17]
    end else begin
      mode_reg <= mode_next;
    end
  end

  // commutation ring; forward A..F, reverse F..A
  bcg_pkg::bcg_state_t state_reg;
  bcg_pkg::bcg_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (mode_reg == bcg_pkg::MODE_ALIGN) begin
      state_next = bcg_pkg::ST_ALIGN; // [R17]
    end else if (tickPulse) begin // [R09]
      case (state_reg)
        bcg_pkg::ST_ALIGN: state_next = fwd ? bcg_pkg::ST_A : bcg_pkg::ST_F;
        bcg_pkg::ST_A: state_next = fwd ? bcg_pkg::ST_B : bcg_pkg::ST_F; // [R12]
        bcg_pkg::ST_B: state_next = fwd ? bcg_pkg::ST_C : bcg_pkg::ST_A;
        bcg_pkg::ST_C: state_next = fwd ? bcg_pkg::ST_D : bcg_pkg::ST_B;
        bcg_pkg::ST_D: state_next = fwd ? bcg_pkg::ST_E : bcg_pkg::ST_C;
        bcg_pkg::ST_E: state_next = fwd ? bcg_pkg::ST_F : bcg_pkg::ST_D;
        bcg_pkg::ST_F: state_next = fwd ? bcg_pkg::ST_A : bcg_pkg::ST_E; // [R10]
        default: state_next = bcg_pkg::ST_ALIGN;
      endcase
    end
    if (restart) begin
      state_next = bcg_pkg::ST_ALIGN; // [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= bcg_pkg::ST_ALIGN;
    end else begin
      state_reg <= state_next;
    end
  end

  // table: low phase, high phase, sensed phase per state
  function automatic logic [5:0] stateRow(input bcg_pkg::bcg_state_t s);
    case (s)
      bcg_pkg::ST_A: stateRow = {bcg_pkg::PH_C, bcg_pkg::PH_A, bcg_pkg::PH_B}; // [R10]
      bcg_pkg::ST_B: stateRow = {bcg_pkg::PH_C, bcg_pkg::PH_B, bcg_pkg::PH_A};
      bcg_pkg::ST_C: stateRow = {bcg_pkg::PH_A, bcg_pkg::PH_B, bcg_pkg::PH_C};
      bcg_pkg::ST_D: stateRow = {bcg_pkg::PH_A, bcg_pkg::PH_C, bcg_pkg::PH_B};
      bcg_pkg::ST_E: stateRow = {bcg_pkg::PH_B, bcg_pkg::PH_C, bcg_pkg::PH_A};
      bcg_pkg::ST_F: stateRow = {bcg_pkg::PH_B, bcg_pkg::PH_A, bcg_pkg::PH_C};
      default: stateRow = {bcg_pkg::PH_NONE, bcg_pkg::PH_NONE, bcg_pkg::PH_NONE};
    endcase
  endfunction

  // phase index to one-hot, used three times
  function automatic logic [2:0] oneHot(input logic [1:0] ph);
    case (ph)
      bcg_pkg::PH_A: oneHot = 3'h1;
      bcg_pkg::PH_B: oneHot = 3'h2;
      bcg_pkg::PH_C: oneHot = 3'h4;
      default: oneHot = 3'h0;
    endcase
  endfunction

  // current-limit one-shot
  logic blankActive;

  bcg_blank_timer #(
    .LEVEL_W(LEVEL_W),
    .CNT_W(CNT_W)
  ) u_blank (
    .clk(clk),
    .srst(srst),
    .currentSenseIn(currentSenseIn),
    .currentLimitLevel(currentLimitLevel),
    .offTimeSetting(offTimeSetting),
    .blankActive(blankActive)
  );

  // raw switch pattern from the state, one low and one high in a running state
  logic [5:0] row;
  logic [2:0] lowOn;
  logic [2:0] highOn;
  logic [2:0] senseSel;

  always_comb begin
    row = stateRow(state_reg);
    if (state_reg == bcg_pkg::ST_ALIGN) begin
      lowOn = 3'h2; // [R11]
      highOn = 3'h5;
      senseSel = 3'h0;
    end else begin
      lowOn = oneHot(row[5:4]); // [R08]
      highOn = oneHot(row[3:2]);
      senseSel = (mode_reg == bcg_pkg::MODE_RUN) ? oneHot(row[1:0]) : 3'h0; // [R18] [R19]
    end
  end

  // final gating registered so outputs are glitch free
  logic [2:0] lowDrive_reg;
  logic [2:0] highDriveN_reg;
  logic [2:0] sense_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      lowDrive_reg <= bcg_pkg::LOW_OFF;
      highDriveN_reg <= bcg_pkg::HIGH_OFF_N;
    end else if (!uvOk) begin
      lowDrive_reg <= bcg_pkg::LOW_OFF; // [R15]
      highDriveN_reg <= bcg_pkg::HIGH_OFF_N;
    end else begin
      // pwm and blanking only touch the low side
      lowDrive_reg <= lowOn & {3{pwmGate & ~blankActive}}; // [R01] [R03] [R04] [R21]
      highDriveN_reg <= ~highOn; // [R02]
    end
  end

  // sense select cleared with the mode; a restart must not leave a stale select behind
  always_ff @(posedge clk) begin
    if (srst) begin
      sense_reg <= 3'h0;
    end else if (mode_next != bcg_pkg::MODE_RUN) begin
      sense_reg <= 3'h0; // [R18]
    end else begin
      sense_reg <= senseSel;
    end
  end

  assign phaseALowDrive = lowDrive_reg[0];
  assign phaseBLowDrive = lowDrive_reg[1];
  assign phaseCLowDrive = lowDrive_reg[2];
  assign phaseAHighDrive_n = highDriveN_reg[0];
  assign phaseBHighDrive_n = highDriveN_reg[1];
  assign phaseCHighDrive_n = highDriveN_reg[2];
  assign phaseASense = sense_reg[0];
  assign phaseBSense = sense_reg[1];
  assign phaseCSense = sense_reg[2];
  assign backEmfEnable = (mode_reg == bcg_pkg::MODE_RUN);
  assign startMode = mode_reg;

endmodule

/* bcg_commutation_gating_props.sv */
/*
  port assertions for the commutation gating block.
  assumes it is bound onto bcg_commutation_gating.
*/
`timescale 1ns/1ns
module bcg_commutation_gating_props #(
  parameter int LEVEL_W = 12,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched inputs
  input wire logic brake,
  input wire logic alignTimingInput,
  input wire logic pwmOn,
  input wire logic undervoltageFlag_n,
  input wire logic [LEVEL_W-1:0] currentSenseIn,
  input wire logic [LEVEL_W-1:0] currentLimitLevel,
  input wire logic [CNT_W-1:0] offTimeSetting,
  // watched outputs
  input wire logic phaseALowDrive,
  input wire logic phaseBLowDrive,
  input wire logic phaseCLowDrive,
  input wire logic phaseAHighDrive_n,
  input wire logic phaseBHighDrive_n,
  input wire logic phaseCHighDrive_n,
  input wire logic phaseASense,
  input wire logic phaseBSense,
  input wire logic phaseCSense,
  input wire logic backEmfEnable,
  input wire logic [1:0] startMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [2:0] lows;
  logic [2:0] highsN;
  logic [2:0] sense;
  logic trip;
  // grouped views; the 5x product is widened to int so it cannot wrap
  assign lows = {phaseCLowDrive, phaseBLowDrive, phaseALowDrive};
  assign highsN = {phaseCHighDrive_n, phaseBHighDrive_n, phaseAHighDrive_n};
  assign sense = {phaseCSense, phaseBSense, phaseASense};
  assign trip = currentSenseIn * 5 > currentLimitLevel;
  a_uv_all_off: assert property ((!undervoltageFlag_n)[*4] |=> lows == 3'h0 && highsN == 3'h7)
    else $error("drives on in undervoltage");
  a_no_shoot: assert property ((lows & ~highsN) == 3'h0)
    else $error("low and high of one phase on");
  a_one_low: assert property ($countones(lows) <= 1 && $countones(~highsN) <= 2)
    else $error("too many switches on");
  a_sense_mode: assert property (backEmfEnable == (startMode == 2'h2) &&
    (startMode == 2'h2 || sense == 3'h0))
    else $error("sense select outside run mode");
  a_pwm_mask: assert property ((!pwmOn)[*4] |=> lows == 3'h0)
    else $error("low side on in pwm off time");
  a_trip_blank: assert property ($rose(trip) && offTimeSetting != 0 |-> ##[1:3] lows == 3'h0)
    else $error("low side not blanked on trip");
  a_align_high: assert property ((startMode == 2'h0 && undervoltageFlag_n)[*5] |-> highsN == 3'h2)
    else $error("align high side pattern wrong");
  a_restart_align: assert property ((brake && !alignTimingInput)[*4] |-> startMode == 2'h0)
    else $error("restart did not force align");
  a_mode_order: assert property (startMode == 2'h0 |=> startMode != 2'h2 && startMode != 2'h3)
    else $error("mode skipped ramp");
endmodule

/* bcg_commutation_gating_test.sv */
/*
  bench for the commutation gating block: start-up, ring order, gating.
  assumes the bridge model and the port checker beside it.
*/
`timescale 1ns/1ns
module bcg_commutation_gating_test;
  logic clk, srst, tickPin, dirFwd, brake, alignIn, rampIn, pwmOn, uvFlag_n, overload;
  logic [11:0] curSense;
  logic [2:0] lo, hiN, sns;
  logic bemf;
  logic [1:0] mode;
  int failures, n_compared;
  // phase index per running state a..f
  int loPh[6] = '{2, 2, 0, 0, 1, 1};
  int hiPh[6] = '{0, 1, 1, 2, 2, 0};
  int snPh[6] = '{1, 0, 2, 1, 0, 2};
  bcg_commutation_gating dut (.clk(clk), .srst(srst), .commutationTickIn(tickPin),
    .directionForward(dirFwd), .brake(brake), .alignTimingInput(alignIn),
    .rampTimingInput(rampIn), .pwmOn(pwmOn), .undervoltageFlag_n(uvFlag_n),
    .currentSenseIn(curSense), .currentLimitLevel(12'h100), .offTimeSetting(16'h0014),
    .phaseALowDrive(lo[0]), .phaseBLowDrive(lo[1]), .phaseCLowDrive(lo[2]),
    .phaseAHighDrive_n(hiN[0]), .phaseBHighDrive_n(hiN[1]), .phaseCHighDrive_n(hiN[2]),
    .phaseASense(sns[0]), .phaseBSense(sns[1]), .phaseCSense(sns[2]),
    .backEmfEnable(bemf), .startMode(mode));
  bcg_bridge_model bridge (.clk(clk), .lowDrive(lo), .highDrive_n(hiN), .overload(overload),
    .currentSenseIn(curSense));
  // s 0..5 running, 6 align, 7 all off; lm masks the low side
  function automatic logic [11:0] ex(logic [1:0] m, int s, bit lm);
    logic [2:0] l, h, n;
    l = (s < 6) ? 3'h1 << loPh[s] : (s == 6 ? 3'h2 : 3'h0);
    h = (s < 6) ? ~(3'h1 << hiPh[s]) : (s == 6 ? 3'h2 : 3'h7);
    n = (m == 2'h2 && s < 6) ? 3'h1 << snPh[s] : 3'h0;
    return {m, m == 2'h2, lm ? 3'h0 : l, h, n};
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // look just after the edge so its updates have landed, then realign on the next edge
  task automatic chk(string what, logic [11:0] exp);
    #1;
    n_compared++;
    if ({mode, bemf, lo, hiN, sns} !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, {mode, bemf, lo, hiN, sns});
    end
    @(posedge clk);
  endtask
  // pin held high 3 cycles, then low long enough for sync and drives
  task automatic tick();
    tickPin <= 1'b1;
    cyc(3);
    tickPin <= 1'b0;
    cyc(6);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the whole run needs well under 600 cycles
  initial begin
    cyc(3000);
    failures++;
    end_sim();
  end
  initial begin
    {srst, dirFwd, pwmOn, uvFlag_n} = 4'hf;
    {tickPin, brake, alignIn, rampIn, overload} = 5'h00;
    cyc(12);
    srst <= 1'b0;
    cyc(4);
    chk("align", ex(2'h0, 6, 0));
    tick();
    chk("align tick", ex(2'h0, 6, 0));
    alignIn <= 1'b1;
    cyc(4);
    for (int i = 0; i < 7; i++) begin
      tick();
      chk("ramp ring", ex(2'h1, i % 6, 0));
    end
    uvFlag_n <= 1'b0;
    cyc(5);
    chk("undervoltage", ex(2'h1, 7, 0));
    uvFlag_n <= 1'b1;
    cyc(5);
    chk("recovered", ex(2'h1, 0, 0));
    $display("test start-up done");
    rampIn <= 1'b1;
    cyc(4);
    chk("run", ex(2'h2, 0, 0));
    tick();
    chk("run step", ex(2'h2, 1, 0));
    pwmOn <= 1'b0;
    cyc(5);
    chk("pwm off", ex(2'h2, 1, 1));
    pwmOn <= 1'b1;
    overload <= 1'b1;
    cyc(6);
    chk("blank", ex(2'h2, 1, 1));
    overload <= 1'b0;
    cyc(25);
    chk("unblank", ex(2'h2, 1, 0));
    $display("test gating done");
    brake <= 1'b1;
    alignIn <= 1'b0;
    cyc(5);
    chk("restart", ex(2'h0, 6, 0));
    dirFwd <= 1'b0;
    brake <= 1'b0;
    rampIn <= 1'b0;
    alignIn <= 1'b1;
    cyc(4);
    for (int i = 5; i >= 0; i--) begin
      tick();
      chk("reverse ring", ex(2'h1, i, 0));
    end
    $display("test reverse done");
    end_sim();
  end
endmodule
bind bcg_commutation_gating bcg_commutation_gating_props #(.LEVEL_W(LEVEL_W), .CNT_W(CNT_W))
  u_props (.clk, .srst, .brake, .alignTimingInput, .pwmOn, .undervoltageFlag_n,
  .currentSenseIn, .currentLimitLevel, .offTimeSetting, .phaseALowDrive, .phaseBLowDrive,
  .phaseCLowDrive, .phaseAHighDrive_n, .phaseBHighDrive_n, .phaseCHighDrive_n,
  .phaseASense, .phaseBSense, .phaseCSense, .backEmfEnable, .startMode);

/* bcg_pkg.sv */
/*
  constants shared by the commutation gating block: state codes, phase
  order, timing figures and counts.
  assumes a 100 MHz system clock.
*/
package bcg_pkg;

  // commutation states; align sits outside the running ring
  typedef enum logic [2:0] {
    ST_ALIGN = 3'b000,
    ST_A = 3'b001,
    ST_B = 3'b010,
    ST_C = 3'b011,
    ST_D = 3'b100,
    ST_E = 3'b101,
    ST_F = 3'b110
  } bcg_state_t;

  // start-up modes
  typedef enum logic [1:0] {
    MODE_ALIGN = 2'b00,
    MODE_RAMP = 2'b01,
    MODE_RUN = 2'b10
  } bcg_mode_t;

  // phase index for one-hot drive vectors, bit 0 is phase A
  localparam logic [1:0] PH_A = 2'h0;
  localparam logic [1:0] PH_B = 2'h1;
  localparam logic [1:0] PH_C = 2'h2;
  localparam logic [1:0] PH_NONE = 2'h3;

  // clock and time figures
  localparam int CLK_MHZ = 100;
  localparam int OFF_TIME_US = 20;
  localparam int OFF_TIME_CYC = OFF_TIME_US * CLK_MHZ;
  localparam int OFF_CNT_W = 16;

  // current-limit trip ratio as 1/5 of the limit level
  localparam int TRIP_DIV = 5;

  // reset values of the drive outputs (all switches off)
  localparam logic [2:0] LOW_OFF = 3'h0;
  localparam logic [2:0] HIGH_OFF_N = 3'h7;

endpackage
